/* File: src/trf_pkg.sv */
// shared constants and types of the radio data path
package trf_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_BITRATE   = 8'h04;
  localparam logic [7:0]  OFS_TXDATA    = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [7:0]  OFS_RXREAD    = 8'h10;
  // control register fields
  localparam int          CTRL_TXMODE   = 0;
  localparam int          CTRL_TXON     = 1;
  localparam int          CTRL_RXON     = 2;
  localparam int          CTRL_THR_LSB  = 4;
  localparam int          THR_W         = 4;
  // status register fields
  localparam int          ST_TXEMPTY    = 0;
  localparam int          ST_UNDERRUN   = 1;
  localparam int          ST_LEVEL      = 2;
  localparam int          ST_OVF        = 3;
  localparam int          ST_ARMED      = 4;
  localparam int          ST_SENDING    = 5;
  localparam int          ST_COUNT_LSB  = 8;
  // reset values
  localparam logic [THR_W-1:0] THR_RST  = 4'h1;
  localparam logic [15:0] BITRATE_RST   = 16'h0040;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'hAA;
  // storage sizes
  localparam int          HOLD_W        = 8;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          CNT_W         = 5;
  // synthesizer settle time before the amplifier comes on
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          TX_CAL_NS     = 1000;
  localparam int          TX_CAL_CYC    = (TX_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {TX_OFF, TX_CAL, TX_SEND} trf_tx_state_t;
endpackage

/* File: src/trf_fifo_if.sv */
// signals between the data path control and its receive bit fifo
`timescale 1ns/1ps
`default_nettype none
interface trf_fifo_if;
  logic                      clear;
  logic                      push;
  logic                      in_bit;
  logic [trf_pkg::CNT_W-1:0] pop_n;
  logic [trf_pkg::CNT_W-1:0] count;
  logic                      head_bit;
  logic [7:0]                head_byte;
  logic                      ovf;
  modport ctl  (output clear, push, in_bit, pop_n, input count, head_bit, head_byte, ovf);
  modport fifo (input clear, push, in_bit, pop_n, output count, head_bit, head_byte, ovf);
endinterface
`default_nettype wire

/* File: src/trf_rx_fifo.sv */
// receive bit fifo, oldest bit at the top of the vector
`timescale 1ns/1ps
`default_nettype none
module trf_rx_fifo #(
  parameter int DEPTH = trf_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  trf_fifo_if.fifo f
);
  logic [DEPTH-1:0]          data_q;
  logic [DEPTH-1:0]          data_d;
  logic [trf_pkg::CNT_W-1:0] cnt_q;
  logic [trf_pkg::CNT_W-1:0] cnt_d;
  logic                      ovf_d;

  always_comb
  begin
    logic [trf_pkg::CNT_W-1:0] n;
    n     = (f.pop_n > cnt_q) ? cnt_q : f.pop_n;
    cnt_d = cnt_q - n;
    data_d = data_q << n;
    ovf_d = 1'b0;
    if (f.push)
    begin
      if (cnt_d == trf_pkg::CNT_W'(DEPTH))
        ovf_d = 1'b1;
      else
      begin
        data_d[DEPTH-1-int'(cnt_d)] = f.in_bit;
        cnt_d = cnt_d + 1'b1;
      end
    end
    if (f.clear)
    begin
      data_d = '0;
      cnt_d  = '0;
      ovf_d  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      data_q <= '0;
      cnt_q  <= '0;
    end
    else
    begin
      data_q <= data_d;
      cnt_q  <= cnt_d;
    end
  end

  assign f.count     = cnt_q;
  assign f.head_bit  = data_q[DEPTH-1];
  assign f.head_byte = data_q[DEPTH-1 -: 8];
  assign f.ovf       = ovf_d;
endmodule
`default_nettype wire

/* File: src/trf_datapath.sv */
// transmit holding registers and receive fifo data path with apb registers
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - with register mode on, host bytes go into one of two 8-bit holding registers.
// - setting transmitter on starts shifting the first holding register at the bit rate.
// - enabling register mode preloads both holding registers with AAh each.
// - clearing transmitter on restores both holding registers to AAh.
// - in register mode SDO is high while a holding register can take a byte.
// - transmitter start powers and calibrates the synthesizer, then the amplifier, then data.
// - a finished byte raises interrupt and SDO together while the other byte waits.
// - the next interrupt after the dummy marks all payload sent, dummy still held.
// - clearing register mode clears underrun, releases interrupt high unless level or overflow is pending, drives SDO low while fifo select is high.
// - in fifo mode demodulated bits shift into a sixteen bit fifo.
// - fifo fills only after valid data and sync pattern are both reported.
// - level interrupt asserts when the bit count reaches a nonzero threshold; status follows.
// - with register mode off and fifo select low, SDO shows the fifo head, one bit per SCK.
// - a read command returns up to eight bits from the fifo head to the host.
// - transmit-empty interrupt only while register mode and transmitter are on.
// - overflow is flagged when more bits arrive than sixteen.
module trf_datapath #(
  parameter int TX_CAL_CYC = trf_pkg::TX_CAL_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck,
  input  wire logic        fifo_select_low,
  output logic             sdo,
  output logic             interrupt_out_low,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        valid_data_flag,
  input  wire logic        sync_detect,
  output logic             synth_en,
  output logic             pa_en,
  output logic             tx_data
);
  localparam int HW = trf_pkg::HOLD_W;

  trf_fifo_if fif ();

  trf_rx_fifo #(
    .DEPTH (trf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk  (clk),
    .rstn (rstn),
    .f    (fif)
  );

  // pin synchronisers
  logic [2:0] sck_q;
  logic [1:0] fsel_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sck_q  <= 3'h0;
      fsel_q <= 2'h3;
    end
    else
    begin
      sck_q  <= {sck_q[1:0], sck};
      fsel_q <= {fsel_q[0], fifo_select_low};
    end
  end
  logic sck_rise;
  logic fsel_low;
  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign fsel_low = ~fsel_q[1];

  // apb decode
  logic setup;
  logic access;
  logic hit;
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign hit    = (paddr == trf_pkg::OFS_CTRL) | (paddr == trf_pkg::OFS_BITRATE)
                | (paddr == trf_pkg::OFS_TXDATA) | (paddr == trf_pkg::OFS_STATUS)
                | (paddr == trf_pkg::OFS_RXREAD);
  assign pready  = penable;
  assign pslverr = access & ~hit;

  logic wr_ctrl;
  logic wr_rate;
  logic wr_tx;
  logic rd_stat;
  logic rd_fifo;
  assign wr_ctrl = access & pwrite & (paddr == trf_pkg::OFS_CTRL);
  assign wr_rate = access & pwrite & (paddr == trf_pkg::OFS_BITRATE);
  assign wr_tx   = access & pwrite & (paddr == trf_pkg::OFS_TXDATA);
  assign rd_stat = access & ~pwrite & (paddr == trf_pkg::OFS_STATUS);
  assign rd_fifo = access & ~pwrite & (paddr == trf_pkg::OFS_RXREAD);

  // control state
  logic                      tx_mode_q, tx_mode_d;
  logic                      tx_on_q, tx_on_d;
  logic                      rx_on_q, rx_on_d;
  logic [trf_pkg::THR_W-1:0] thr_q, thr_d;
  logic [15:0]               rate_q, rate_d;
  logic [HW-1:0]             hold_q [2];
  logic [HW-1:0]             hold_d [2];
  logic [1:0]                full_q, full_d;
  logic                      rd_idx_q, rd_idx_d;
  logic                      underrun_q, underrun_d;
  logic                      ovf_q, ovf_d;
  logic                      armed_q, armed_d;
  trf_pkg::trf_tx_state_t    st_q, st_d;
  logic [15:0]               cal_q, cal_d;
  logic [15:0]               tmr_q, tmr_d;
  logic [2:0]                bit_q, bit_d;
  logic [trf_pkg::CNT_W-1:0] rdn_q, rdn_d;
  logic [31:0]               prdata_q, prdata_d;
  logic                      sdo_q, sdo_d;
  logic                      irq_q, irq_d;
  logic                      txd_q, txd_d;

  logic tx_empty;
  logic level;
  assign tx_empty = tx_mode_q & tx_on_q & ~&full_q;
  assign level    = rx_on_q & (thr_q != '0)
                  & (fif.count >= trf_pkg::CNT_W'(thr_q));

  always_comb
  begin
    logic byte_end;
    logic tgt;
    tx_mode_d  = tx_mode_q;
    tx_on_d    = tx_on_q;
    rx_on_d    = rx_on_q;
    thr_d      = thr_q;
    rate_d     = rate_q;
    hold_d     = hold_q;
    full_d     = full_q;
    rd_idx_d   = rd_idx_q;
    underrun_d = underrun_q;
    st_d       = st_q;
    cal_d      = cal_q;
    tmr_d      = tmr_q;
    bit_d      = bit_q;
    byte_end   = 1'b0;
    tgt        = full_q[rd_idx_q] ? ~rd_idx_q : rd_idx_q;
    if (wr_ctrl)
    begin
      tx_mode_d = pwdata[trf_pkg::CTRL_TXMODE];
      tx_on_d   = pwdata[trf_pkg::CTRL_TXON];
      rx_on_d   = pwdata[trf_pkg::CTRL_RXON];
      thr_d     = pwdata[trf_pkg::CTRL_THR_LSB +: trf_pkg::THR_W];
    end
    if (wr_rate)
      rate_d = pwdata[15:0];
    // transmit sequencer
    unique case (st_q)
      trf_pkg::TX_OFF:
      begin
        cal_d = '0;
        if (tx_on_q)
          st_d = trf_pkg::TX_CAL;
      end
      trf_pkg::TX_CAL:
      begin
        cal_d = cal_q + 16'h0001;
        if (cal_q >= 16'(TX_CAL_CYC - 1))
        begin
          st_d     = trf_pkg::TX_SEND;
          tmr_d    = '0;
          bit_d    = '0;
          rd_idx_d = 1'b0;
        end
      end
      trf_pkg::TX_SEND:
      begin
        tmr_d = tmr_q + 16'h0001;
        if (16'(tmr_q + 16'h0001) >= rate_q)
        begin
          tmr_d = '0;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7)
            byte_end = 1'b1;
        end
      end
    endcase
    if (byte_end)
    begin
      full_d[rd_idx_q] = 1'b0;
      rd_idx_d = ~rd_idx_q;
      if (!full_q[~rd_idx_q])
        underrun_d = 1'b1;
    end
    if (wr_tx && tx_mode_q)
    begin
      if (&full_q)
        underrun_d = 1'b1;
      hold_d[tgt] = pwdata[HW-1:0];
      full_d[tgt] = 1'b1;
    end
    if (!tx_on_q)
      st_d = trf_pkg::TX_OFF;
    // preload on register mode rising or transmitter falling
    if ((tx_mode_d && !tx_mode_q) || (tx_on_q && !tx_on_d))
    begin
      hold_d[0] = trf_pkg::PREAMBLE_BYTE;
      hold_d[1] = trf_pkg::PREAMBLE_BYTE;
      full_d    = 2'h3;
      rd_idx_d  = 1'b0;
    end
    if (!tx_mode_q || !tx_on_q)
      underrun_d = 1'b0;
  end

  // receive side, status clear and read data
  always_comb
  begin
    armed_d = armed_q;
    ovf_d   = ovf_q;
    rdn_d   = rdn_q;
    if (!rx_on_q)
      armed_d = 1'b0;
    else if (valid_data_flag && sync_detect)
      armed_d = 1'b1;
    if (rd_stat)
      ovf_d = 1'b0;
    if (fif.ovf)
      ovf_d = 1'b1;
    if (setup)
      rdn_d = (fif.count > trf_pkg::CNT_W'(8)) ? trf_pkg::CNT_W'(8) : fif.count;
    prdata_d = prdata_q;
    if (setup && !pwrite)
    begin
      prdata_d = '0;
      unique case (paddr)
        trf_pkg::OFS_CTRL:
        begin
          prdata_d[trf_pkg::CTRL_TXMODE] = tx_mode_q;
          prdata_d[trf_pkg::CTRL_TXON]   = tx_on_q;
          prdata_d[trf_pkg::CTRL_RXON]   = rx_on_q;
          prdata_d[trf_pkg::CTRL_THR_LSB +: trf_pkg::THR_W] = thr_q;
        end
        trf_pkg::OFS_BITRATE: prdata_d[15:0] = rate_q;
        trf_pkg::OFS_STATUS:
        begin
          prdata_d[trf_pkg::ST_TXEMPTY]  = tx_empty;
          prdata_d[trf_pkg::ST_UNDERRUN] = underrun_q;
          prdata_d[trf_pkg::ST_LEVEL]    = level;
          prdata_d[trf_pkg::ST_OVF]      = ovf_q;
          prdata_d[trf_pkg::ST_ARMED]    = armed_q;
          prdata_d[trf_pkg::ST_SENDING]  = (st_q == trf_pkg::TX_SEND);
          prdata_d[trf_pkg::ST_COUNT_LSB +: trf_pkg::CNT_W] = fif.count;
        end
        trf_pkg::OFS_RXREAD: prdata_d[7:0] = fif.head_byte;
        default: prdata_d = '0;
      endcase
    end
    // pins
    if (tx_mode_q)
      sdo_d = ~&full_q;
    else if (fsel_low)
      sdo_d = fif.head_bit;
    else
      sdo_d = 1'b0;
    irq_d = ~(tx_empty | underrun_q | level | ovf_q);
    txd_d = (st_q == trf_pkg::TX_SEND) ? hold_q[rd_idx_q][3'h7 - bit_q] : 1'b0;
  end

  always_comb
  begin
    fif.clear  = ~rx_on_q;
    fif.push   = armed_q & rx_on_q & rx_bit_valid;
    fif.in_bit = rx_bit;
    fif.pop_n  = (rd_fifo ? rdn_q : '0)
               + ((sck_rise && fsel_low && !tx_mode_q) ? trf_pkg::CNT_W'(1) : '0);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tx_mode_q  <= 1'b0;
      tx_on_q    <= 1'b0;
      rx_on_q    <= 1'b0;
      thr_q      <= trf_pkg::THR_RST;
      rate_q     <= trf_pkg::BITRATE_RST;
      hold_q[0]  <= trf_pkg::PREAMBLE_BYTE;
      hold_q[1]  <= trf_pkg::PREAMBLE_BYTE;
      full_q     <= 2'h3;
      rd_idx_q   <= 1'b0;
      underrun_q <= 1'b0;
      ovf_q      <= 1'b0;
      armed_q    <= 1'b0;
      st_q       <= trf_pkg::TX_OFF;
      cal_q      <= '0;
      tmr_q      <= '0;
      bit_q      <= '0;
      rdn_q      <= '0;
      prdata_q   <= '0;
      sdo_q      <= 1'b0;
      irq_q      <= 1'b1;
      txd_q      <= 1'b0;
    end
    else
    begin
      tx_mode_q  <= tx_mode_d;
      tx_on_q    <= tx_on_d;
      rx_on_q    <= rx_on_d;
      thr_q      <= thr_d;
      rate_q     <= rate_d;
      hold_q     <= hold_d;
      full_q     <= full_d;
      rd_idx_q   <= rd_idx_d;
      underrun_q <= underrun_d;
      ovf_q      <= ovf_d;
      armed_q    <= armed_d;
      st_q       <= st_d;
      cal_q      <= cal_d;
      tmr_q      <= tmr_d;
      bit_q      <= bit_d;
      rdn_q      <= rdn_d;
      prdata_q   <= prdata_d;
      sdo_q      <= sdo_d;
      irq_q      <= irq_d;
      txd_q      <= txd_d;
    end
  end

  assign prdata            = prdata_q;
  assign sdo               = sdo_q;
  assign interrupt_out_low = irq_q;
  assign synth_en          = (st_q != trf_pkg::TX_OFF);
  assign pa_en             = (st_q == trf_pkg::TX_SEND);
  assign tx_data           = txd_q;
endmodule
`default_nettype wire

/* File: sim/trf_datapath_props.sv */
// concurrent checks on the data path ports
`timescale 1ns/1ps
`default_nettype none
module trf_datapath_props #(
  parameter int TX_CAL_CYC = 4
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck,
  input wire logic        fifo_select_low,
  input wire logic        sdo,
  input wire logic        interrupt_out_low,
  input wire logic        rx_bit,
  input wire logic        rx_bit_valid,
  input wire logic        valid_data_flag,
  input wire logic        sync_detect,
  input wire logic        synth_en,
  input wire logic        pa_en,
  input wire logic        tx_data
);
  // amplifier comes on this many cycles after the third calibrating cycle
  localparam int CAL_GAP = TX_CAL_CYC - 2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence ctrl_off;
    psel && penable && pwrite && paddr == trf_pkg::OFS_CTRL && pwdata[2:0] == 3'h0
      && fifo_select_low;
  endsequence
  sequence all_quiet;
    interrupt_out_low && !sdo && !synth_en;
  endsequence
  off_quiet_a: assert property (ctrl_off |-> ##[1:3] all_quiet)
    else $error("outputs not quiet after control cleared");
  ready_echo_a: assert property (psel |-> pready == penable)
    else $error("pready differs from penable");
  unmapped_err_a: assert property (psel && penable && paddr > trf_pkg::OFS_RXREAD |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (psel && penable && paddr[1:0] == 2'h0
    && paddr <= trf_pkg::OFS_RXREAD |-> !pslverr)
    else $error("error on mapped access");
  amp_synth_a: assert property (pa_en |-> synth_en)
    else $error("amplifier on without synthesizer");
  cal_gap_a: assert property ($rose(synth_en) |-> !pa_en [*3] ##[CAL_GAP:CAL_GAP] pa_en)
    else $error("amplifier timing after transmitter on wrong");
  tx_idle_a: assert property (!pa_en && !$past(pa_en) |-> !tx_data)
    else $error("serial data active while not sending");
  byte_flag_a: assert property ($fell(interrupt_out_low) && pa_en |-> ##[0:3] sdo)
    else $error("ready flag missing at byte end");
  empty_sync_a: assert property ($rose(sdo) && pa_en && fifo_select_low
    |-> !interrupt_out_low)
    else $error("ready flag and interrupt not together");
endmodule
bind trf_datapath trf_datapath_props #(.TX_CAL_CYC(TX_CAL_CYC)) u_props (.*);
`default_nettype wire

/* File: sim/trf_host_model.sv */
// host side of the serial fifo port
`timescale 1ns/1ps
`default_nettype none
module trf_host_model (
  output logic     sck,
  output logic     fifo_select_low,
  input wire logic sdo
);
  initial
  begin
    sck = 1'b0;
    fifo_select_low = 1'b1;
  end
  // sck stays low outside frames, 80 ns period keeps phases long enough
  task automatic pull(input int n, output logic [7:0] v);
    v = 8'h00;
    // pin edges fall on falling clock edges, midway between rising edges
    #2 fifo_select_low = 1'b0;
    #120;
    for (int i = 0; i < n; i++)
    begin
      v = {v[6:0], sdo};
      sck = 1'b1;
      #40;
      sck = 1'b0;
      #40;
    end
    fifo_select_low = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: sim/trf_datapath_tb.sv */
// self-checking bench of the data path
`timescale 1ns/1ps
`default_nettype none
module trf_datapath_tb;
  localparam logic [7:0] RX_PAT = 8'hD4;
  logic        clk, rstn, psel, penable, pwrite, rx_bit, rx_bit_valid;
  logic        valid_data_flag, sync_detect, err, sck, fifo_select_low;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, rd, prdata;
  logic        pready, pslverr, sdo, interrupt_out_low, synth_en, pa_en, tx_data;
  logic [31:0] rec_q;
  logic [7:0]  ph_q;
  int          fail_count = 0;
  int          cmp_count = 0;
  trf_datapath #(.TX_CAL_CYC(4)) dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .fifo_select_low(fifo_select_low), .sdo(sdo),
    .interrupt_out_low(interrupt_out_low), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .valid_data_flag(valid_data_flag), .sync_detect(sync_detect), .synth_en(synth_en),
    .pa_en(pa_en), .tx_data(tx_data));
  trf_host_model host (.sck(sck), .fifo_select_low(fifo_select_low), .sdo(sdo));
  always #2 clk = ~clk;
  // sample the serial bit mid-period, bit rate set to 4 cycles
  always @(posedge clk)
  begin
    ph_q <= pa_en ? ph_q + 8'h01 : 8'h00;
    if (pa_en && ph_q[1:0] == 2'h2)
      rec_q <= {rec_q[30:0], tx_data};
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k == 50)
    begin
      fail_count++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq;
    int k = 0;
    while (interrupt_out_low !== 1'b0 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 3000)
    begin
      fail_count++;
      end_of_test;
    end
  endtask
  task automatic push(input logic b);
    rx_bit <= b;
    rx_bit_valid <= 1'b1;
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    rx_bit = 0; rx_bit_valid = 0; valid_data_flag = 0; sync_detect = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b0, trf_pkg::OFS_TXDATA, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    apb(1'b1, trf_pkg::OFS_BITRATE, 32'h4);
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h3);
    wait_irq;
    repeat (3) @(posedge clk);
    chk(32'(sdo), 32'h1);
    apb(1'b1, trf_pkg::OFS_TXDATA, 32'hC3);
    repeat (3) @(posedge clk);
    chk(32'({sdo, interrupt_out_low}), 32'h1);
    wait_irq;
    apb(1'b1, trf_pkg::OFS_TXDATA, 32'h0);
    repeat (3) @(posedge clk);
    wait_irq;
    chk(32'(rec_q[23:0]), 32'hAAAAC3);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    repeat (40) @(posedge clk);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk({rd[31:2], synth_en, rd[0]}, 32'h0);
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h3);
    wait_irq;
    chk(32'(rec_q[7:0]), 32'hAA);
    repeat (40) @(posedge clk);
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'({sdo, interrupt_out_low}), 32'h1);
    $display("transmit test done");
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h84);
    for (int i = 0; i < 4; i++) push(1'b1);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    valid_data_flag <= 1'b1;
    sync_detect <= 1'b1;
    @(posedge clk);
    for (int i = 7; i >= 0; i--) push(RX_PAT[i]);
    repeat (4) @(posedge clk);
    chk(32'(interrupt_out_low), 32'h0);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h814);
    apb(1'b0, trf_pkg::OFS_RXREAD, 32'h0);
    chk(rd, 32'(RX_PAT));
    repeat (3) @(posedge clk);
    chk(32'(interrupt_out_low), 32'h1);
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h14);
    push(1'b1);
    push(1'b0);
    push(1'b1);
    host.pull(3, v);
    chk(32'(v), 32'h5);
    repeat (4) @(posedge clk);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h1F04, 32'h0);
    for (int i = 0; i < 17; i++) push(1'b1);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h1F0C, 32'h100C);
    apb(1'b0, trf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h1F08, 32'h1000);
    valid_data_flag <= 1'b0;
    sync_detect <= 1'b0;
    apb(1'b1, trf_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    $display("receive test done");
    end_of_test;
  end
endmodule
`default_nettype wire
